// *** hdl/ssx_alu.v ***
// ssx_alu.v: subtract, swap, xor and direction-load execution datapath with flags.
// assumes ops arrive as one-cycle pulses; file ops read their operand one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "ssx_consts.vh"

module ssx_alu (
	input wire clk_sys,
	input wire sys_rst,
	input wire opValid,
	input wire [3:0] opCode,
	input wire [7:0] literal,
	input wire [`SSX_FILE_AW-1:0] fileAddr,
	input wire destSel,
	output wire busy,
	output reg done,
	input wire [2:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWr,
	input wire regRd,
	output reg [7:0] regRdData,
	input wire fileWrExt,
	input wire [`SSX_FILE_AW-1:0] fileAddrExt,
	input wire [7:0] fileWrDataExt,
	output reg [7:0] acc,
	output reg carryFlag,
	output reg digitCarryFlag,
	output reg zeroFlag,
	output reg [7:0] portADirection,
	output reg [7:0] portBDirection,
	output reg [7:0] portCDirection
);

	localparam ST_IDLE = 1'b0;
	localparam ST_FILE = 1'b1;

	reg state;
	reg [3:0] heldOp;
	reg [`SSX_FILE_AW-1:0] heldAddr;
	reg heldDest;
	wire [7:0] fileData;

	// minuend - subtrahend - borrowIn, returns {carry, digit carry, diff}
	// a set carry means no borrow out of bit 7; digit carry the same for bit 3
	function [9:0] subFlags;
		input [7:0] minuend;
		input [7:0] subtrahend;
		input borrowIn;
		reg [8:0] full;
		reg [4:0] low;
		begin
			full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrowIn};
			low = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrowIn};
			subFlags = {~full[8], ~low[4], full[7:0]};
		end
	endfunction

	function isZero;
		input [7:0] val;
		begin
			isZero = (val == 8'h00);
		end
	endfunction

	// true for ops whose operand comes out of the file memory
	function usesFile;
		input [3:0] code;
		begin
			case (code)
				`SSX_OP_SUB_FILE: usesFile = 1'b1;
				`SSX_OP_SUB_FILE_BORROW: usesFile = 1'b1;
				`SSX_OP_SWAP_FILE: usesFile = 1'b1;
				`SSX_OP_XOR_FILE: usesFile = 1'b1;
				default: usesFile = 1'b0;
			endcase
		end
	endfunction

	// software write strobe aimed at one register address
	function swWrHit;
		input wr;
		input [2:0] addr;
		input [2:0] target;
		begin
			swWrHit = wr && (addr == target);
		end
	endfunction

	// direction load aimed at one port select
	function dirHit;
		input load;
		input [2:0] sel;
		input [2:0] target;
		begin
			dirHit = load && (sel == target);
		end
	endfunction

	// file operand ops need one cycle for the registered memory read
	wire needsFile = usesFile(opCode);
	assign busy = (state == ST_FILE);

	reg [9:0] subRes;
	reg [7:0] result;
	reg next_carry;
	reg next_digit;
	reg next_zero;
	reg updSub;
	reg updZero;
	reg wrResult;
	always @* begin
		subRes = 10'h000;
		result = 8'h00;
		updSub = 1'b0;
		updZero = 1'b0;
		wrResult = 1'b0;
		if (state == ST_FILE) begin
			wrResult = 1'b1;
			case (heldOp)
				`SSX_OP_SUB_FILE: begin
					subRes = subFlags(fileData, acc, 1'b0);
					updSub = 1'b1;
				end
				`SSX_OP_SUB_FILE_BORROW: begin
					subRes = subFlags(fileData, acc, ~carryFlag);
					updSub = 1'b1;
				end
				`SSX_OP_SWAP_FILE: begin
					result = {fileData[3:0], fileData[7:4]};
				end
				`SSX_OP_XOR_FILE: begin
					result = fileData ^ acc;
					updZero = 1'b1;
				end
				default: begin
					wrResult = 1'b0;
				end
			endcase
		end else if (opValid) begin
			case (opCode)
				`SSX_OP_SUB_LIT: begin
					subRes = subFlags(literal, acc, 1'b0);
					updSub = 1'b1;
					wrResult = 1'b1;
				end
				`SSX_OP_XOR_LIT: begin
					result = literal ^ acc;
					updZero = 1'b1;
					wrResult = 1'b1;
				end
				default: begin
					wrResult = 1'b0;
				end
			endcase
		end
		if (updSub) begin
			result = subRes[7:0];
		end
		next_carry = updSub ? subRes[9] : carryFlag;
		next_digit = updSub ? subRes[8] : digitCarryFlag;
		next_zero = (updSub || updZero) ? isZero(result) : zeroFlag;
	end

	// literal ops always land in the accumulator; file ops follow the held dest bit
	wire resToFile = (state == ST_FILE) && (heldDest == `SSX_DEST_FILE);
	wire resToAcc = wrResult && !resToFile;
	wire loadDir = (state == ST_IDLE) && opValid && (opCode == `SSX_OP_LOAD_DIR);

	// the alu write-back takes the memory write port over the preload path
	ssx_file_ram u_ram (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.rdAddr((state == ST_IDLE) ? fileAddr : heldAddr),
		.rdData(fileData),
		.wrEn((wrResult && resToFile) || fileWrExt),
		.wrAddr((wrResult && resToFile) ? heldAddr : fileAddrExt),
		.wrData((wrResult && resToFile) ? result : fileWrDataExt)
	);

	// file ops spend one extra cycle in ST_FILE while the operand is read
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			heldOp <= `SSX_OP_NOP;
			heldAddr <= {`SSX_FILE_AW{1'b0}};
			heldDest <= `SSX_DEST_ACC;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (opValid && needsFile) begin
						state <= ST_FILE;
						heldOp <= opCode;
						heldAddr <= fileAddr;
						heldDest <= destSel;
					end else if (opValid) begin
						done <= 1'b1;
					end
				end
				ST_FILE: begin
					state <= ST_IDLE;
					done <= 1'b1;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// software writes lose to a same-cycle alu update of the same register
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			acc <= `SSX_ACC_RST;
			carryFlag <= 1'b0;
			digitCarryFlag <= 1'b0;
			zeroFlag <= 1'b0;
		end else begin
			if (resToAcc) begin
				acc <= result;
			end else if (swWrHit(regWr, regAddr, `SSX_ADDR_ACC)) begin
				acc <= regWrData;
			end
			if (wrResult) begin
				carryFlag <= next_carry;
				digitCarryFlag <= next_digit;
				zeroFlag <= next_zero;
			end else if (swWrHit(regWr, regAddr, `SSX_ADDR_STATUS)) begin
				carryFlag <= regWrData[`SSX_BIT_CARRY];
				digitCarryFlag <= regWrData[`SSX_BIT_DIGIT];
				zeroFlag <= regWrData[`SSX_BIT_ZERO];
			end
		end
	end

	// direction load leaves every flag alone
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			portADirection <= `SSX_DIR_RST;
			portBDirection <= `SSX_DIR_RST;
			portCDirection <= `SSX_DIR_RST;
		end else begin
			if (dirHit(loadDir, literal[2:0], `SSX_DIR_SEL_A)) begin
				portADirection <= acc;
			end else if (swWrHit(regWr, regAddr, `SSX_ADDR_DIR_A)) begin
				portADirection <= regWrData;
			end
			if (dirHit(loadDir, literal[2:0], `SSX_DIR_SEL_B)) begin
				portBDirection <= acc;
			end else if (swWrHit(regWr, regAddr, `SSX_ADDR_DIR_B)) begin
				portBDirection <= regWrData;
			end
			if (dirHit(loadDir, literal[2:0], `SSX_DIR_SEL_C)) begin
				portCDirection <= acc;
			end else if (swWrHit(regWr, regAddr, `SSX_ADDR_DIR_C)) begin
				portCDirection <= regWrData;
			end
		end
	end

	// read data stand for one cycle after the strobe and are zero otherwise
	reg [7:0] next_rdData;
	always @* begin
		next_rdData = `SSX_RD_RST;
		if (regRd) begin
			case (regAddr)
				`SSX_ADDR_ACC: next_rdData = acc;
				`SSX_ADDR_STATUS: next_rdData = {5'h00, zeroFlag, digitCarryFlag, carryFlag};
				`SSX_ADDR_DIR_A: next_rdData = portADirection;
				`SSX_ADDR_DIR_B: next_rdData = portBDirection;
				`SSX_ADDR_DIR_C: next_rdData = portCDirection;
				default: next_rdData = `SSX_RD_RST;
			endcase
		end
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			regRdData <= `SSX_RD_RST;
		end else begin
			regRdData <= next_rdData;
		end
	end

endmodule

`default_nettype wire

// *** hdl/ssx_consts.vh ***
// ssx_consts.vh: opcode codes, flag positions, direction selects and register addresses.
// included by the datapath and its register file; definitions only.
`ifndef SSX_CONSTS_VH
`define SSX_CONSTS_VH

// operation codes on the op port
`define SSX_OP_NOP 4'h0
`define SSX_OP_SUB_LIT 4'h1
`define SSX_OP_SUB_FILE 4'h2
`define SSX_OP_SUB_FILE_BORROW 4'h3
`define SSX_OP_SWAP_FILE 4'h4
`define SSX_OP_LOAD_DIR 4'h5
`define SSX_OP_XOR_LIT 4'h6
`define SSX_OP_XOR_FILE 4'h7

// direction register selects
`define SSX_DIR_SEL_A 3'h5
`define SSX_DIR_SEL_B 3'h6
`define SSX_DIR_SEL_C 3'h7

// destination bit values
`define SSX_DEST_ACC 1'h0
`define SSX_DEST_FILE 1'h1

// reset values
`define SSX_ACC_RST 8'h00
`define SSX_DIR_RST 8'hff
`define SSX_FILE_RST 8'h00
`define SSX_RD_RST 8'h00

// software register port addresses
`define SSX_ADDR_ACC 3'h0
`define SSX_ADDR_STATUS 3'h1
`define SSX_ADDR_DIR_A 3'h2
`define SSX_ADDR_DIR_B 3'h3
`define SSX_ADDR_DIR_C 3'h4

// status bit positions
`define SSX_BIT_CARRY 0
`define SSX_BIT_DIGIT 1
`define SSX_BIT_ZERO 2

// file register space
`define SSX_FILE_AW 7
`define SSX_FILE_DEPTH 128

`endif

// *** hdl/ssx_file_ram.v ***
// ssx_file_ram.v: 128 x 8 file register memory, registered read port.
// assumes one clock, synchronous active-high reset clears only the read register.
`timescale 1ns/1ps
`default_nettype none
`include "ssx_consts.vh"

module ssx_file_ram (
	input wire clk_sys,
	input wire sys_rst,
	input wire [`SSX_FILE_AW-1:0] rdAddr,
	output reg [7:0] rdData,
	input wire wrEn,
	input wire [`SSX_FILE_AW-1:0] wrAddr,
	input wire [7:0] wrData
);

	reg [7:0] mem [0:`SSX_FILE_DEPTH-1];

	always @(posedge clk_sys) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			rdData <= `SSX_FILE_RST;
		end else begin
			rdData <= mem[rdAddr];
		end
	end

endmodule

`default_nettype wire

// *** testbench/ssx_alu_chk.sv ***
// ssx_alu_chk.sv: port assertions for the alu datapath.
// assumes it is bound onto ssx_alu; one clock, sync active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "ssx_consts.vh"
module ssx_alu_chk (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic opValid,
	input wire logic [3:0] opCode,
	input wire logic [7:0] literal,
	input wire logic destSel,
	input wire logic busy,
	input wire logic [7:0] acc,
	input wire logic carryFlag,
	input wire logic digitCarryFlag,
	input wire logic zeroFlag,
	input wire logic [7:0] portADirection
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire [2:0] flags = {carryFlag, digitCarryFlag, zeroFlag};
	sequence s_take(logic [3:0] c);
		opValid && !busy && opCode == c;
	endsequence
	sequence s_file;
		opValid && !busy && opCode inside {4'h2, 4'h3, 4'h4, 4'h7};
	endsequence
	a_sub_lit_acc: assert property (s_take(4'h1) |=> acc == $past(literal) - $past(acc))
		else $error("literal subtract result wrong");
	a_sub_lit_carry: assert property (s_take(4'h1) |=> carryFlag == ($past(literal) >= $past(acc)))
		else $error("literal subtract carry wrong");
	a_sub_digit: assert property (s_take(4'h1)
		|=> digitCarryFlag == ($past(literal[3:0]) >= $past(acc[3:0])))
		else $error("literal subtract digit carry wrong");
	a_sub_lit_zero: assert property (s_take(4'h1) |=> zeroFlag == (acc == 8'h00))
		else $error("subtract zero flag wrong");
	a_xor_lit_acc: assert property (s_take(4'h6)
		|=> acc == ($past(literal) ^ $past(acc)) && zeroFlag == (acc == 8'h00))
		else $error("literal xor wrong");
	a_dir_load_a: assert property (s_take(4'h5) ##0 (literal[2:0] == 3'h5)
		|=> portADirection == $past(acc))
		else $error("direction load wrong");
	a_dir_flags: assert property (s_take(4'h5) |=> $stable(flags))
		else $error("direction load touched flags");
	a_swap_flags: assert property (s_take(4'h4) |=> ##1 $stable(flags))
		else $error("swap touched flags");
	a_file_dest_keep: assert property (s_file ##0 destSel |=> ##1 $stable(acc))
		else $error("file destination altered accumulator");
endmodule
bind ssx_alu ssx_alu_chk i_ssx_alu_chk (.clk_sys, .sys_rst, .opValid, .opCode, .literal,
	.destSel, .busy, .acc, .carryFlag, .digitCarryFlag, .zeroFlag, .portADirection);
`default_nettype wire

// *** testbench/test_subtract_swap_xor_alu_ops.sv ***
// test_subtract_swap_xor_alu_ops.sv: self-checking bench for ssx_alu.
// assumes the alu and its checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "ssx_consts.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_subtract_swap_xor_alu_ops;
	logic clk_sys = 0, sys_rst = 1, opValid = 0, destSel = 0, regWr = 0, regRd = 0;
	logic fileWrExt = 0, rdPend = 0, busy, done, carryFlag, digitCarryFlag, zeroFlag;
	logic [3:0] opCode = 0;
	logic [7:0] literal = 0, regWrData = 0, fileWrDataExt = 0, regRdData, acc, eRd;
	logic [7:0] portADirection, portBDirection, portCDirection, mem [0:127];
	logic [7:0] mAcc = 0, mA = 8'hff, mB = 8'hff, mC = 8'hff;
	logic [`SSX_FILE_AW-1:0] fileAddr = 0, fileAddrExt = 0;
	logic [2:0] regAddr = 0;
	logic c = 0, dc = 0, z = 0;
	logic [34:0] opQ [$], eOp;
	logic [7:0] rdQ [$];
	logic bsyQ [$];
	logic takePend = 0, eBsy;
	integer seed = 32'h0d08, bad_count = 0, n_compared = 0, i;
	ssx_alu i_ssx_alu (.clk_sys, .sys_rst, .opValid, .opCode, .literal, .fileAddr, .destSel,
		.busy, .done, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .fileWrExt,
		.fileAddrExt, .fileWrDataExt, .acc, .carryFlag, .digitCarryFlag, .zeroFlag,
		.portADirection, .portBDirection, .portCDirection);
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		rdPend <= regRd;
		takePend <= opValid && !busy;
		if (takePend) begin
			eBsy = bsyQ.pop_front();
			`CHK(busy, eBsy)
		end
		if (!sys_rst && done === 1'b1 && opQ.size() > 0) begin
			eOp = opQ.pop_front();
			`CHK({acc, carryFlag, digitCarryFlag, zeroFlag, portADirection, portBDirection,
				portCDirection}, eOp)
		end
		if (rdPend) begin
			eRd = rdQ.pop_front();
			`CHK(regRdData, eRd)
		end
	end
	task automatic sub8(input [7:0] a, b, input bi, output [7:0] r);
		logic [8:0] t;
		logic [4:0] n;
		t = {1'b0, a} - {1'b0, b} - bi;
		n = {1'b0, a[3:0]} - {1'b0, b[3:0]} - bi;
		r = t[7:0];
		c = !t[8];
		dc = !n[4];
	endtask
	task automatic do_op(input [3:0] code, input [7:0] k, input [6:0] f, input d);
		logic [7:0] r;
		integer w;
		r = mem[f];
		case (code)
			1: sub8(k, mAcc, 0, r);
			2: sub8(r, mAcc, 0, r);
			3: sub8(r, mAcc, !c, r);
			4: r = {r[3:0], r[7:4]};
			6: r = mAcc ^ k;
			7: r = mAcc ^ r;
		endcase
		if (code inside {1, 2, 3, 6, 7})
			z = (r == 0);
		if (code == 5) begin
			if (k[2:0] == 5)
				mA = mAcc;
			if (k[2:0] == 6)
				mB = mAcc;
			if (k[2:0] == 7)
				mC = mAcc;
		end else if (code == 1 || code == 6 || (code != 0 && !d))
			mAcc = r;
		else
			mem[f] = r;
		opQ.push_back({mAcc, c, dc, z, mA, mB, mC});
		bsyQ.push_back(code inside {2, 3, 4, 7});
		@(posedge clk_sys);
		opValid <= 1;
		opCode <= code;
		literal <= k;
		fileAddr <= f;
		destSel <= d;
		@(posedge clk_sys);
		opValid <= 0;
		for (w = 0; w < 6 && done !== 1'b1; w++)
			@(posedge clk_sys);
	endtask
	task automatic wr_rd(input [7:0] v, input [2:0] a);
		@(posedge clk_sys);
		regWr <= 1;
		regAddr <= 0;
		regWrData <= v;
		mAcc = v;
		@(posedge clk_sys);
		regWr <= 0;
		regRd <= 1;
		regAddr <= a;
		case (a)
			0: rdQ.push_back(mAcc);
			1: rdQ.push_back({5'h0, z, dc, c});
			2: rdQ.push_back(mA);
			3: rdQ.push_back(mB);
			4: rdQ.push_back(mC);
			default: rdQ.push_back(8'h00);
		endcase
		@(posedge clk_sys);
		regRd <= 0;
	endtask
	task tally_and_finish;
		if (opQ.size() != 0 || bsyQ.size() != 0)
			bad_count++;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#(25 * 30000);
		bad_count++;
		tally_and_finish;
	end
	initial begin
		repeat (10) @(posedge clk_sys);
		sys_rst <= 0;
		for (i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			mem[i] = $random(seed);
			fileWrExt <= 1;
			fileAddrExt <= i;
			fileWrDataExt <= mem[i];
		end
		@(posedge clk_sys);
		fileWrExt <= 0;
		do_op(1, 0, 0, 0);
		for (i = 0; i < 300; i++) begin
			wr_rd($random(seed), $random(seed));
			do_op({$random(seed)} % 8, $random(seed), $random(seed) & 7, $random(seed));
		end
		// mid-run reset: accumulator, flags and directions return to reset values
		@(posedge clk_sys);
		sys_rst <= 1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 0;
		mAcc = 8'h00;
		c = 0;
		dc = 0;
		z = 0;
		mA = 8'hff;
		mB = 8'hff;
		mC = 8'hff;
		do_op(5, 8'h05, 0, 0);
		do_op(1, 8'h00, 0, 0);
		repeat (4) @(posedge clk_sys);
		tally_and_finish;
	end
endmodule
`default_nettype wire
